//--- logic/ccsr_map.svh
// Address map, reset values and timing counts of the core state block.
// Assumes it is included by bare name from the design files that need it.
`ifndef CCSR_MAP_SVH
`define CCSR_MAP_SVH

`define CCSR_ADDR_PTR_FIRST 8'h80
`define CCSR_ADDR_PTR_SECOND 8'h81
`define CCSR_ADDR_SDIR_FIRST 8'h82
`define CCSR_ADDR_SDIR_SECOND 8'h83
`define CCSR_ADDR_ACC 8'hFF
`define CCSR_REG_RST 8'h00
`define CCSR_PC_W 12
`define CCSR_PC_RST_VEC 12'hFFE
`define CCSR_STACK_DEPTH 6
`define CCSR_MC_DIV 13
`define CCSR_TMR_DIV 12
`define CCSR_RST_DELAY 2048
`define CCSR_CYC_BITBR 3'h5
`define CCSR_CYC_FOUR 3'h4
`define CCSR_CYC_TWO 3'h2

`endif

//--- logic/ccsr_pkg.sv
// Types shared by the core state block and its user.
// Assumes the user drives commands with these encodings.
package ccsr_pkg;

    typedef enum logic [3:0] {
        PC_HOLD = 4'h0,
        PC_INC = 4'h1,
        PC_JUMP = 4'h2,
        PC_CALL = 4'h3,
        PC_REL = 4'h4,
        PC_IRQ = 4'h5,
        PC_NMI = 4'h6,
        PC_RET = 4'h7,
        PC_INTERRUPT_RETURN_INSTR = 4'h8
    } ccsr_pc_op_t;

    typedef enum logic [2:0] {
        FL_NONE = 3'h0,
        FL_ARITH = 3'h1,
        FL_LOGIC = 3'h2,
        FL_BITTEST = 3'h3,
        FL_ROTL = 3'h4
    } ccsr_flag_op_t;

    typedef enum logic [1:0] {
        CTX_NORMAL = 2'h0,
        CTX_IRQ = 2'h1,
        CTX_NMI = 2'h2
    } ccsr_ctx_t;

    typedef enum logic [2:0] {
        IC_BITBR = 3'h0,
        IC_BRANCH = 3'h1,
        IC_BITMAN = 3'h2,
        IC_LOAD = 3'h3,
        IC_ALU = 3'h4,
        IC_COND = 3'h5,
        IC_PROG = 3'h6
    } ccsr_iclass_t;

    typedef enum logic [1:0] {
        RST_HOLD = 2'b00,
        RST_DELAY = 2'b01,
        RST_RUN = 2'b11
    } ccsr_rst_st_t;

endpackage

//--- logic/ccsr_clkdiv.sv
// Free-running divider giving a one-cycle tick every DIV reference clocks.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ccsr_clkdiv #(
    parameter int DIV = 13
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    output logic o_tick,
    output logic [4:0] o_phase
);
    logic [4:0] cnt_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q <= 5'h00;
        end else if (cnt_q == 5'(DIV - 1)) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    assign o_tick = (cnt_q == 5'(DIV - 1));
    assign o_phase = cnt_q;
endmodule // ccsr_clkdiv

//--- logic/ccsr_stack.sv
// Saturating hardware return stack, shifting levels on push and pop.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/1ps
module ccsr_stack #(
    parameter int W = 12,
    parameter int DEPTH = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [W-1:0] i_data,
    output logic [W-1:0] o_top,
    output logic o_empty,
    output logic [2:0] o_depth
);
    logic [W-1:0] lvl_q [DEPTH];
    logic [2:0] depth_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                lvl_q[i] <= '0;
            end
        end else if (i_push) begin
            // The deepest level falls off the end when the stack is full.
            for (int i = DEPTH - 1; i > 0; i--) begin
                lvl_q[i] <= lvl_q[i-1];
            end
            lvl_q[0] <= i_data;
        end else if (i_pop && depth_q != 3'h0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                lvl_q[i] <= lvl_q[i+1];
            end
            lvl_q[DEPTH-1] <= '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_clear) begin
            depth_q <= 3'h0;
        end else if (i_push && depth_q != 3'(DEPTH)) begin
            depth_q <= depth_q + 3'h1;
        end else if (i_pop && depth_q != 3'h0) begin
            depth_q <= depth_q - 3'h1;
        end
    end

    assign o_top = lvl_q[0];
    assign o_empty = (depth_q == 3'h0);
    assign o_depth = depth_q;
endmodule // ccsr_stack

//--- logic/ccsr_core.sv
// Programmer-visible core state: data-space registers, program counter,
// context flag pairs, return stack, clock dividers and reset entry.
// Assumes an outside sequencer issues one command per machine-cycle tick.
`timescale 1ns/1ps
`include "ccsr_map.svh"

// Notes on behaviour
// - Eight-bit accumulator, read and written as data-space location FFh.
// - Two pointer registers at data addresses 80h and 81h.
// - Two short-direct registers at data addresses 82h and 83h.
// - Program counter is twelve bits, covering 4096 program bytes.
// - Counter increments per fetch; relative branch adds signed offset.
// - Counter loads target, relative sum, vector or popped stack value.
// - Three carry/zero pairs: normal, maskable and non-maskable context.
// - Interrupt entry switches pair; interrupt return restores the previous pair.
// - Pairs keep values across switches; only the active pair is touched.
// - Carry follows carry or borrow, tested bit, and rotate-left.
// - Zero flag set when the last arithmetic or logic result is zero.
// - After any reset the non-maskable context and its pair are active.
// - Six-level twelve-bit stack; call or interrupt shifts down, pushes counter.
// - Either return pops level one into the counter and shifts up.
// - Stack saturates both ways; empty return leaves the counter and stack unchanged.
// - A machine cycle lasts thirteen oscillator periods.
// - Timer and watchdog tick is the oscillator divided by twelve.
// - Instructions last five, four or two machine cycles by class.
// - Reset comes from the pin, power-on detection or watchdog timeout.
// - Pin is active low; internal reset is delayed and holds while low.
// - Reset in run or wait halts execution and pulls all I/O up.
// - Reset in stop restarts the oscillator and pulls all I/O up.
// - Internal reset releases 2048 clocks after the external release.
// - Reset clears the stack and loads the counter with 0FFEh.
module ccsr_core #(
    parameter int RST_DELAY = `CCSR_RST_DELAY,
    parameter int MC_DIV = `CCSR_MC_DIV,
    parameter int TMR_DIV = `CCSR_TMR_DIV
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_pin_n,
    input wire logic i_por_active,
    input wire logic i_wdg_timeout,
    input wire logic i_stop_req,
    input wire logic [7:0] i_ds_addr,
    input wire logic i_ds_wr,
    input wire logic i_ds_rd,
    input wire logic [7:0] i_ds_wdata,
    input wire logic i_acc_we,
    input wire logic [7:0] i_acc_wdata,
    input wire ccsr_pkg::ccsr_pc_op_t i_pc_op,
    input wire logic [11:0] i_pc_target,
    input wire logic [7:0] i_rel_offset,
    input wire ccsr_pkg::ccsr_flag_op_t i_flag_op,
    input wire logic i_alu_carry,
    input wire logic [7:0] i_alu_result,
    input wire logic i_bit_value,
    input wire logic i_instr_start,
    input wire ccsr_pkg::ccsr_iclass_t i_instr_class,
    output logic [7:0] o_accumulator,
    output logic [7:0] o_pointer_reg_first,
    output logic [7:0] o_pointer_reg_second,
    output logic [7:0] o_short_direct_reg_first,
    output logic [7:0] o_short_direct_reg_second,
    output logic [7:0] o_ds_rdata,
    output logic o_ds_hit,
    output logic [11:0] o_pc,
    output logic [2:0] o_stack_depth,
    output logic o_carry,
    output logic o_zero,
    output ccsr_pkg::ccsr_ctx_t o_ctx,
    output logic o_mc_tick,
    output logic o_latch_settle,
    output logic o_tmr_tick,
    output logic o_instr_last,
    output logic o_core_rst_n,
    output logic o_io_pullup,
    output logic o_run,
    output logic o_osc_en
);
    logic pin_meta_q;
    logic pin_sync_q;
    logic por_meta_q;
    logic por_sync_q;
    logic src_active;
    ccsr_pkg::ccsr_rst_st_t rst_st_q;
    logic [11:0] dly_cnt_q;
    logic core_rst;
    logic stop_q;
    logic [4:0] mc_phase;
    logic step;
    logic [7:0] acc_q;
    logic [7:0] ptr_first_q;
    logic [7:0] ptr_second_q;
    logic [7:0] sdir_first_q;
    logic [7:0] sdir_second_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic [11:0] pc_q;
    logic push;
    logic pop;
    logic [11:0] stk_top;
    logic stk_empty;
    ccsr_pkg::ccsr_ctx_t ctx_q;
    ccsr_pkg::ccsr_ctx_t nmi_prev_q;
    logic [2:0] carry_q;
    logic [2:0] zero_q;
    logic [2:0] cyc_q;

    function automatic logic [2:0] class_cycles(input ccsr_pkg::ccsr_iclass_t ic);
        case (ic)
            ccsr_pkg::IC_BITBR: class_cycles = `CCSR_CYC_BITBR;
            ccsr_pkg::IC_COND,
            ccsr_pkg::IC_PROG: class_cycles = `CCSR_CYC_TWO;
            default: class_cycles = `CCSR_CYC_FOUR;
        endcase
    endfunction

    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        wr_hit = i_ds_wr && (addr == reg_addr);
    endfunction

    // Pin and power-on inputs are asynchronous to the oscillator clock.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            por_meta_q <= 1'b0;
            por_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= i_reset_pin_n;
            pin_sync_q <= pin_meta_q;
            por_meta_q <= i_por_active;
            por_sync_q <= por_meta_q;
        end
    end

    assign src_active = !pin_sync_q || por_sync_q || i_wdg_timeout;

    // Any source restarts the delay, so a short pulse still gets a full reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rst_st_q <= ccsr_pkg::RST_HOLD;
            dly_cnt_q <= 12'h000;
        end else if (src_active) begin
            rst_st_q <= ccsr_pkg::RST_HOLD;
            dly_cnt_q <= 12'h000;
        end else begin
            case (rst_st_q)
                ccsr_pkg::RST_HOLD: begin
                    rst_st_q <= ccsr_pkg::RST_DELAY;
                    dly_cnt_q <= 12'h000;
                end
                ccsr_pkg::RST_DELAY: begin
                    if (dly_cnt_q == 12'(RST_DELAY - 1)) begin
                        rst_st_q <= ccsr_pkg::RST_RUN;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 12'h001;
                    end
                end
                ccsr_pkg::RST_RUN: begin
                    rst_st_q <= ccsr_pkg::RST_RUN;
                end
                default: begin
                    rst_st_q <= ccsr_pkg::RST_HOLD;
                end
            endcase
        end
    end

    assign core_rst = (rst_st_q != ccsr_pkg::RST_RUN);
    assign o_core_rst_n = !core_rst;
    assign o_io_pullup = core_rst;

    // Stop mode gates the oscillator; only a reset source can wake it.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || core_rst) begin
            stop_q <= 1'b0;
        end else if (i_stop_req) begin
            stop_q <= 1'b1;
        end
    end

    assign o_osc_en = !stop_q || src_active;
    assign o_run = !core_rst && !stop_q;

    ccsr_clkdiv #(
        .DIV(MC_DIV)
    ) u_mc_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_tick(o_mc_tick),
        .o_phase(mc_phase)
    );

    ccsr_clkdiv #(
        .DIV(TMR_DIV)
    ) u_tmr_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_tick(o_tmr_tick),
        .o_phase()
    );

    // The last period of each machine cycle is kept free for latch settling.
    assign o_latch_settle = (mc_phase == 5'(MC_DIV - 1));
    assign step = o_mc_tick && o_run;

    // A data-space write beats an ALU result aimed at the accumulator.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            acc_q <= `CCSR_REG_RST;
        end else if (wr_hit(i_ds_addr, `CCSR_ADDR_ACC)) begin
            acc_q <= i_ds_wdata;
        end else if (i_acc_we) begin
            acc_q <= i_acc_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ptr_first_q <= `CCSR_REG_RST;
            ptr_second_q <= `CCSR_REG_RST;
        end else begin
            if (wr_hit(i_ds_addr, `CCSR_ADDR_PTR_FIRST)) begin
                ptr_first_q <= i_ds_wdata;
            end
            if (wr_hit(i_ds_addr, `CCSR_ADDR_PTR_SECOND)) begin
                ptr_second_q <= i_ds_wdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sdir_first_q <= `CCSR_REG_RST;
            sdir_second_q <= `CCSR_REG_RST;
        end else begin
            if (wr_hit(i_ds_addr, `CCSR_ADDR_SDIR_FIRST)) begin
                sdir_first_q <= i_ds_wdata;
            end
            if (wr_hit(i_ds_addr, `CCSR_ADDR_SDIR_SECOND)) begin
                sdir_second_q <= i_ds_wdata;
            end
        end
    end

    // Reads are registered; addresses outside the core answer no hit and zero.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (i_ds_rd) begin
            hit_q <= 1'b1;
            case (i_ds_addr)
                `CCSR_ADDR_ACC: rdata_q <= acc_q;
                `CCSR_ADDR_PTR_FIRST: rdata_q <= ptr_first_q;
                `CCSR_ADDR_PTR_SECOND: rdata_q <= ptr_second_q;
                `CCSR_ADDR_SDIR_FIRST: rdata_q <= sdir_first_q;
                `CCSR_ADDR_SDIR_SECOND: rdata_q <= sdir_second_q;
                default: begin
                    rdata_q <= 8'h00;
                    hit_q <= 1'b0;
                end
            endcase
        end else begin
            hit_q <= 1'b0;
        end
    end

    assign push = step && (i_pc_op == ccsr_pkg::PC_CALL || i_pc_op == ccsr_pkg::PC_IRQ
        || i_pc_op == ccsr_pkg::PC_NMI);
    assign pop = step && !stk_empty && (i_pc_op == ccsr_pkg::PC_RET
        || i_pc_op == ccsr_pkg::PC_INTERRUPT_RETURN_INSTR);

    ccsr_stack #(
        .W(`CCSR_PC_W),
        .DEPTH(`CCSR_STACK_DEPTH)
    ) u_stack (
        .i_ref_clk(i_ref_clk),
        .i_clear(!i_rst_n || core_rst),
        .i_push(push),
        .i_pop(pop),
        .i_data(pc_q),
        .o_top(stk_top),
        .o_empty(stk_empty),
        .o_depth(o_stack_depth)
    );

    // The counter already points past the return opcode, so an empty pop holds it.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || core_rst) begin
            pc_q <= `CCSR_PC_RST_VEC;
        end else if (step) begin
            case (i_pc_op)
                ccsr_pkg::PC_INC: pc_q <= pc_q + 12'h001;
                ccsr_pkg::PC_JUMP,
                ccsr_pkg::PC_CALL,
                ccsr_pkg::PC_IRQ,
                ccsr_pkg::PC_NMI: pc_q <= i_pc_target;
                ccsr_pkg::PC_REL: pc_q <= pc_q + {{4{i_rel_offset[7]}}, i_rel_offset};
                ccsr_pkg::PC_RET,
                ccsr_pkg::PC_INTERRUPT_RETURN_INSTR: begin
                    if (!stk_empty) begin
                        pc_q <= stk_top;
                    end
                end
                default: pc_q <= pc_q;
            endcase
        end
    end

    // Maskable service always starts from normal, so only the non-maskable
    // entry needs the context it interrupted remembered.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || core_rst) begin
            ctx_q <= ccsr_pkg::CTX_NMI;
            nmi_prev_q <= ccsr_pkg::CTX_NORMAL;
        end else if (step) begin
            case (i_pc_op)
                ccsr_pkg::PC_IRQ: ctx_q <= ccsr_pkg::CTX_IRQ;
                ccsr_pkg::PC_NMI: begin
                    nmi_prev_q <= ctx_q;
                    ctx_q <= ccsr_pkg::CTX_NMI;
                end
                ccsr_pkg::PC_INTERRUPT_RETURN_INSTR: begin
                    if (ctx_q == ccsr_pkg::CTX_NMI) begin
                        ctx_q <= nmi_prev_q;
                    end else begin
                        ctx_q <= ccsr_pkg::CTX_NORMAL;
                    end
                end
                default: ctx_q <= ctx_q;
            endcase
        end
    end

    // Only the active pair is written; the others keep their values.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            carry_q <= 3'h0;
            zero_q <= 3'h0;
        end else begin
            case (i_flag_op)
                ccsr_pkg::FL_ARITH: begin
                    carry_q[ctx_q] <= i_alu_carry;
                    zero_q[ctx_q] <= (i_alu_result == 8'h00);
                end
                ccsr_pkg::FL_LOGIC: zero_q[ctx_q] <= (i_alu_result == 8'h00);
                ccsr_pkg::FL_BITTEST: carry_q[ctx_q] <= i_bit_value;
                ccsr_pkg::FL_ROTL: carry_q[ctx_q] <= i_alu_carry;
                default: carry_q <= carry_q;
            endcase
        end
    end

    // Instruction length counter, loaded at start and run on machine ticks.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || core_rst) begin
            cyc_q <= 3'h0;
        end else if (i_instr_start) begin
            cyc_q <= class_cycles(i_instr_class);
        end else if (step && cyc_q != 3'h0) begin
            cyc_q <= cyc_q - 3'h1;
        end
    end

    assign o_instr_last = step && (cyc_q == 3'h1);
    assign o_accumulator = acc_q;
    assign o_pointer_reg_first = ptr_first_q;
    assign o_pointer_reg_second = ptr_second_q;
    assign o_short_direct_reg_first = sdir_first_q;
    assign o_short_direct_reg_second = sdir_second_q;
    assign o_ds_rdata = rdata_q;
    assign o_ds_hit = hit_q;
    assign o_pc = pc_q;
    assign o_carry = carry_q[ctx_q];
    assign o_zero = zero_q[ctx_q];
    assign o_ctx = ctx_q;
endmodule // ccsr_core

//--- tb/ccsr_core_properties.sv
// Checker of the core state block, seeing only the top module's ports.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ccsr_core_properties (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_ds_addr,
    input wire logic i_ds_wr,
    input wire logic i_ds_rd,
    input wire logic [7:0] i_ds_wdata,
    input wire ccsr_pkg::ccsr_pc_op_t i_pc_op,
    input wire logic [11:0] i_pc_target,
    input wire ccsr_pkg::ccsr_flag_op_t i_flag_op,
    input wire logic i_alu_carry,
    input wire logic [7:0] i_alu_result,
    input wire logic [7:0] o_accumulator,
    input wire logic [7:0] o_pointer_reg_first,
    input wire logic [7:0] o_ds_rdata,
    input wire logic o_ds_hit,
    input wire logic [11:0] o_pc,
    input wire logic [2:0] o_stack_depth,
    input wire logic o_carry,
    input wire logic o_zero,
    input wire logic o_mc_tick,
    input wire logic o_tmr_tick,
    input wire logic o_core_rst_n,
    input wire logic o_io_pullup,
    input wire logic o_run
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_mc_period: assert property (o_mc_tick |=> !o_mc_tick ##12 o_mc_tick)
        else $error("mc tick gap");
    a_tmr_period: assert property (o_tmr_tick |=> !o_tmr_tick ##11 o_tmr_tick)
        else $error("timer tick gap");
    a_acc_read_back: assert property (i_ds_rd && i_ds_addr == 8'hFF |=>
        o_ds_hit && o_ds_rdata == $past(o_accumulator)) else $error("acc read wrong");
    a_ptr_write_seen: assert property (i_ds_wr && i_ds_addr == 8'h80 |=>
        o_pointer_reg_first == $past(i_ds_wdata)) else $error("ptr write lost");
    a_pc_step_inc: assert property (o_mc_tick && o_run && i_pc_op == ccsr_pkg::PC_INC |=>
        o_pc == $past(o_pc) + 12'h001) else $error("pc not stepped");
    a_pc_jump_load: assert property (o_mc_tick && o_run && i_pc_op == ccsr_pkg::PC_JUMP |=>
        o_pc == $past(i_pc_target)) else $error("pc not jumped");
    a_rst_io_pullup: assert property (!o_core_rst_n |-> o_io_pullup && !o_run ##1
        o_pc == 12'hFFE && o_stack_depth == 3'h0) else $error("reset state wrong");
    a_stack_depth_max: assert property (o_stack_depth <= 3'h6)
        else $error("depth over six");
    a_flag_arith_upd: assert property (i_flag_op == ccsr_pkg::FL_ARITH && !o_mc_tick |=>
        o_carry == $past(i_alu_carry) && o_zero == ($past(i_alu_result) == 8'h00))
        else $error("arith flags wrong");
endmodule // ccsr_core_properties

//--- tb/ccsr_prog_rom.sv
// Program memory model answering the core's fetch address.
// Assumes a combinational read by the sequencer side of the bench.
`timescale 1ns/1ps
module ccsr_prog_rom (
    input wire logic [11:0] i_addr,
    output logic [11:0] o_word
);
    // Each word carries the low address nibble, so a fetch from a wrong address shows.
    assign o_word = {i_addr[3:0], 8'h10};
endmodule // ccsr_prog_rom

//--- tb/ccsr_core_tb_top.sv
// Self-checking bench of the core state block with a program memory model.
// Assumes the shortened reset delay below; everything else at its default.
`timescale 1ns/1ps
module ccsr_core_tb_top;
    localparam int DLY = 8;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_reset_pin_n = 1'b1, i_por_active = 1'b0;
    logic i_wdg_timeout = 1'b0, i_stop_req = 1'b0, i_ds_wr = 1'b0, i_ds_rd = 1'b0, i_acc_we = 1'b0;
    logic i_alu_carry = 1'b0, i_bit_value = 1'b0, i_instr_start = 1'b0;
    logic [7:0] i_ds_addr = 8'h00, i_ds_wdata = 8'h00, i_acc_wdata = 8'h00;
    logic [7:0] i_rel_offset = 8'h00, i_alu_result = 8'h00;
    logic [11:0] i_pc_target = 12'h000;
    ccsr_pkg::ccsr_pc_op_t i_pc_op = ccsr_pkg::PC_HOLD;
    ccsr_pkg::ccsr_flag_op_t i_flag_op = ccsr_pkg::FL_NONE;
    ccsr_pkg::ccsr_iclass_t i_instr_class = ccsr_pkg::IC_BITBR;
    logic [7:0] o_accumulator, o_pointer_reg_first, o_pointer_reg_second, o_short_direct_reg_first;
    logic [7:0] o_short_direct_reg_second, o_ds_rdata;
    logic [11:0] o_pc, rom_word;
    logic [2:0] o_stack_depth;
    ccsr_pkg::ccsr_ctx_t o_ctx;
    logic o_ds_hit, o_carry, o_zero, o_mc_tick, o_latch_settle, o_tmr_tick, o_instr_last;
    logic o_core_rst_n, o_io_pullup, o_run, o_osc_en;
    logic [7:0] port_val [5];
    logic [7:0] addr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    int len [7] = '{5, 4, 4, 4, 4, 2, 2};
    int mismatches = 0, checks = 0, n;

    assign port_val = '{o_pointer_reg_first, o_pointer_reg_second, o_short_direct_reg_first,
                        o_short_direct_reg_second, o_accumulator};
    always #2 i_ref_clk = ~i_ref_clk;

    ccsr_core #(.RST_DELAY(DLY)) uut (.*);
    ccsr_prog_rom u_rom (.i_addr(o_pc), .o_word(rom_word));

    task automatic check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k = 1);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wait_mc;
        tick();
        for (int j = 0; j < 30 && !o_mc_tick; j++) tick();
    endtask

    task automatic ds_write(input logic [7:0] a, input logic [7:0] d);
        i_ds_addr = a;
        i_ds_wdata = d;
        i_ds_wr = 1'b1;
        tick();
        i_ds_wr = 1'b0;
        tick();
    endtask

    task automatic ds_read(input logic [7:0] a, input logic [8:0] exp);
        i_ds_addr = a;
        i_ds_rd = 1'b1;
        tick();
        i_ds_rd = 1'b0;
        check({o_ds_hit, o_ds_rdata}, exp);
        tick();
    endtask

    task automatic step(input ccsr_pkg::ccsr_pc_op_t op, input logic [11:0] t = 12'h000);
        wait_mc();
        i_pc_op = op;
        i_pc_target = t;
        tick();
        i_pc_op = ccsr_pkg::PC_HOLD;
    endtask

    task automatic flag(input ccsr_pkg::ccsr_flag_op_t op, logic c, logic [7:0] r, logic b, logic [1:0] exp);
        tick();
        i_flag_op = op;
        i_alu_carry = c;
        i_alu_result = r;
        i_bit_value = b;
        tick();
        i_flag_op = ccsr_pkg::FL_NONE;
        check({o_carry, o_zero}, exp);
    endtask

    task automatic wait_run;
        for (n = 0; !o_core_rst_n && n < 40; n++) tick();
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        i_rst_n = 1'b1;
        check({o_pc, o_stack_depth, o_io_pullup}, {12'hFFE, 3'h0, 1'b1});
        check(o_ctx, ccsr_pkg::CTX_NMI);
        wait_run();
        check(n >= DLY && n <= DLY + 3, 1);
        $display("test reset entry done");
        for (int i = 0; i < 5; i++) ds_read(addr[i], 9'h100);
        for (int i = 0; i < 5; i++) ds_write(addr[i], addr[i] ^ 8'h5A);
        for (int i = 0; i < 5; i++) begin
            check(port_val[i], addr[i] ^ 8'h5A);
            ds_read(addr[i], {1'b1, addr[i] ^ 8'h5A});
        end
        ds_read(8'h84, 9'h000);
        ds_read(8'hFE, 9'h000);
        i_acc_we = 1'b1;
        i_acc_wdata = 8'h3C;
        tick();
        i_acc_we = 1'b0;
        ds_read(8'hFF, 9'h13C);
        $display("test data space done");
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 20 && !(k ? o_tmr_tick : o_mc_tick); j++) tick();
            if (!k) check(o_latch_settle, 1'b1);
            tick();
            for (n = 1; !(k ? o_tmr_tick : o_mc_tick) && n < 30; n++) tick();
            check(n, k ? 12 : 13);
        end
        $display("test dividers done");
        step(ccsr_pkg::PC_JUMP, rom_word);
        check(o_pc, 12'hE10);
        step(ccsr_pkg::PC_INC);
        check(o_pc, 12'hE11);
        i_rel_offset = 8'hFE;
        step(ccsr_pkg::PC_REL);
        check(o_pc, 12'hE0F);
        step(ccsr_pkg::PC_CALL, 12'h123);
        check({o_pc, o_stack_depth}, {12'h123, 3'h1});
        for (int i = 0; i < 2; i++) begin
            step(ccsr_pkg::PC_RET);
            check({o_pc, o_stack_depth}, {12'hE0F, 3'h0});
        end
        for (int i = 0; i < 7; i++) begin
            step(ccsr_pkg::PC_CALL, 12'h100 + 12'(i));
            check({o_pc, o_stack_depth}, {12'h100 + 12'(i), 3'(i < 6 ? i + 1 : 6)});
        end
        for (int i = 0; i < 6; i++) begin
            step(ccsr_pkg::PC_RET);
            check({o_pc, o_stack_depth}, {12'h105 - 12'(i), 3'(5 - i)});
        end
        $display("test counter and stack done");
        flag(ccsr_pkg::FL_ARITH, 1'b1, 8'h00, 1'b0, 2'b11);
        step(ccsr_pkg::PC_INTERRUPT_RETURN_INSTR);
        check({o_ctx, o_carry, o_zero, o_pc}, {ccsr_pkg::CTX_NORMAL, 2'b00, 12'h100});
        flag(ccsr_pkg::FL_ARITH, 1'b1, 8'h03, 1'b0, 2'b10);
        flag(ccsr_pkg::FL_LOGIC, 1'b0, 8'h00, 1'b0, 2'b11);
        step(ccsr_pkg::PC_IRQ, 12'hFF6);
        check({o_ctx, o_carry, o_zero, o_pc}, {ccsr_pkg::CTX_IRQ, 2'b00, 12'hFF6});
        flag(ccsr_pkg::FL_BITTEST, 1'b0, 8'h00, 1'b1, 2'b10);
        step(ccsr_pkg::PC_NMI, 12'hFFC);
        check({o_ctx, o_carry, o_zero}, {ccsr_pkg::CTX_NMI, 2'b11});
        step(ccsr_pkg::PC_INTERRUPT_RETURN_INSTR);
        check({o_ctx, o_carry, o_zero, o_pc}, {ccsr_pkg::CTX_IRQ, 2'b10, 12'hFF6});
        step(ccsr_pkg::PC_INTERRUPT_RETURN_INSTR);
        check({o_ctx, o_carry, o_zero, o_pc}, {ccsr_pkg::CTX_NORMAL, 2'b11, 12'h100});
        flag(ccsr_pkg::FL_ROTL, 1'b0, 8'h00, 1'b0, 2'b01);
        $display("test flags done");
        for (int c = 0; c < 7; c++) begin
            wait_mc();
            i_instr_start = 1'b1;
            i_instr_class = ccsr_pkg::ccsr_iclass_t'(c);
            tick();
            i_instr_start = 1'b0;
            n = 0;
            for (int j = 0; j < 100 && !o_instr_last; j++) begin
                tick();
                if (o_mc_tick) n++;
            end
            check(n, len[c]);
        end
        $display("test instruction timing done");
        step(ccsr_pkg::PC_CALL, 12'h222);
        i_stop_req = 1'b1;
        tick();
        i_stop_req = 1'b0;
        tick(3);
        check({o_run, o_osc_en}, 2'b00);
        for (int s = 0; s < 3; s++) begin
            {i_reset_pin_n, i_por_active, i_wdg_timeout} = {s != 0, s == 1, s == 2};
            tick(4);
            check({o_core_rst_n, o_io_pullup, o_run, o_osc_en}, 4'b0101);
            {i_reset_pin_n, i_por_active, i_wdg_timeout} = 3'b100;
            wait_run();
            check(n >= DLY && n <= DLY + 5, 1);
            check({o_pc, o_stack_depth, o_accumulator}, {12'hFFE, 3'h0, 8'h3C});
            check(o_ctx, ccsr_pkg::CTX_NMI);
        end
        $display("test reset sources done");
        tally_and_finish();
    end

    // The whole sequence takes about a thousand clocks; this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule // ccsr_core_tb_top

bind ccsr_core ccsr_core_properties u_props (.*);
